// file: hdl/pcap_pkg.sv
package pcap_pkg;
   // ==========================================
   // host i/o port map (byte addresses)
   localparam logic [15:0] PCAP_PWR_ARB_ADDR = 16'h0022;
   localparam logic [15:0] PCAP_CFG_ADDR_PORT = 16'h0cf8;
   localparam logic [15:0] PCAP_CFG_DATA_PORT = 16'h0cfc;
   localparam logic [3:0] PCAP_FULL_DWORD_BE = 4'hf;
   localparam logic [3:0] PCAP_PWR_ARB_BE = 4'h4;
   // ==========================================
   // reset values and field layout
   localparam logic [7:0] PCAP_PWR_ARB_RESET = 8'h00;
   localparam logic [31:0] PCAP_CFG_ADDR_RESET = 32'h0000_0000;
   localparam logic [31:0] PCAP_CFG_ADDR_WMASK = 32'h80ff_fffc;
   localparam int PCAP_ENABLE_POS = 31;
   localparam int PCAP_ARBITER_DISABLE_BIT_POS = 0;
   localparam logic [7:0] PCAP_OWN_BUS = 8'h00;
   localparam logic [4:0] PCAP_OWN_DEV = 5'h00;
   localparam logic [2:0] PCAP_OWN_FUNC = 3'h0;
   localparam logic [4:0] PCAP_MAX_IDSEL_DEV = 5'h14;
   localparam int PCAP_IDSEL_BASE = 11;
   localparam logic [1:0] PCAP_TYPE0_LOW = 2'b00;
   localparam logic [1:0] PCAP_TYPE1_LOW = 2'b01;
   // misc control register sits at config offset 79h: dword 1eh, lane 1, bit 6
   localparam logic [5:0] PCAP_MISC_CTRL_DW = 6'h1e;
   localparam int PCAP_MISC_CTRL_LANE = 1;
   localparam int PCAP_MISC_PM_BIT = 14;
   // ==========================================
   // pci bus commands
   localparam logic [3:0] PCAP_CMD_IO_RD = 4'h2;
   localparam logic [3:0] PCAP_CMD_IO_WR = 4'h3;
   localparam logic [3:0] PCAP_CMD_CFG_RD = 4'ha;
   localparam logic [3:0] PCAP_CMD_CFG_WR = 4'hb;
   localparam int PCAP_NUM_REQ = 5;
   typedef enum logic [1:0] {PCAP_IDLE, PCAP_INT_WAIT, PCAP_PCI_WAIT, PCAP_DONE} pcap_state_type;
endpackage

// file: hdl/pcap_sync.sv
`timescale 1ns/1ps
module pcap_sync #(
   parameter int WIDTH = 5,
   parameter logic [WIDTH-1:0] INIT = '1
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   // ==========================================
   // two-flop synchroniser per bit
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta_r;
         logic hold_r;
         always_ff @(posedge mclk) begin
            if (srst) begin
               meta_r <= INIT[i];
               hold_r <= INIT[i];
            end else begin
               meta_r <= async_in[i];
               hold_r <= meta_r;
            end
         end
         assign sync_out[i] = hold_r;
      end
   endgenerate
endmodule

// file: hdl/pcap_xlate.sv
`timescale 1ns/1ps
module pcap_xlate
   import pcap_pkg::*;
(
   input wire logic [31:0] cfg_addr,
   output logic [31:0] pci_addr,
   output logic is_own_target,
   output logic is_type1
);
   logic [7:0] bus_num;
   logic [4:0] dev_num;
   logic [2:0] func_num;
   logic [5:0] reg_num;
   logic [20:0] idsel;

   assign bus_num = cfg_addr[23:16];
   assign dev_num = cfg_addr[15:11];
   assign func_num = cfg_addr[10:8];
   assign reg_num = cfg_addr[7:2];

   assign is_own_target = (bus_num == PCAP_OWN_BUS) && (dev_num == PCAP_OWN_DEV)
                          && (func_num == PCAP_OWN_FUNC);
   assign is_type1 = (bus_num != PCAP_OWN_BUS);

   // ==========================================
   // one-hot select decode
   always_comb begin
      idsel = '0;
      // device n on line 11+n, none for device 0 or above 20
      if (dev_num != PCAP_OWN_DEV && dev_num <= PCAP_MAX_IDSEL_DEV) begin
         idsel[dev_num] = 1'b1;
      end
   end

   always_comb begin
      if (is_type1) begin
         // type 1 layout, low bits 01
         pci_addr = {8'h00, cfg_addr[23:2], PCAP_TYPE1_LOW};
      end else begin
         pci_addr = {idsel, func_num, reg_num, PCAP_TYPE0_LOW};
      end
   end
endmodule

// file: hdl/pcap_top.sv
`timescale 1ns/1ps
module pcap_top
   import pcap_pkg::*;
#(
   parameter int NUM_REQ = PCAP_NUM_REQ
) (
   input wire logic mclk,
   input wire logic srst,
   // host i/o request
   input wire logic io_valid,
   output logic io_ready,
   input wire logic io_write,
   input wire logic [15:0] io_addr,
   input wire logic [3:0] io_be,
   input wire logic [31:0] io_wdata,
   output logic io_done,
   output logic [31:0] io_rdata,
   // internal configuration register file
   output logic cfg_req,
   output logic cfg_write,
   output logic [5:0] cfg_reg_num,
   output logic [3:0] cfg_be,
   output logic [31:0] cfg_wdata,
   input wire logic cfg_ack,
   input wire logic [31:0] cfg_rdata,
   // pci master cycle engine
   output logic pci_req,
   output logic [3:0] pci_cmd,
   output logic [31:0] pci_addr,
   output logic [3:0] pci_be,
   output logic [31:0] pci_wdata,
   input wire logic pci_ack,
   input wire logic [31:0] pci_rdata,
   // arbiter request pins
   input wire logic [NUM_REQ-2:0] pci_bus_req_n,
   input wire logic southbridge_hold_request_n,
   output logic [NUM_REQ-1:0] arb_req_active,
   output logic arbiter_disable_bit
);
   import pcap_pkg::*;

   typedef struct packed {
      pcap_state_type st;
      logic [31:0] config_address_port;
      logic [7:0] power_arbiter_control;
      logic misc_pm_enable;
      logic cfg_req;
      logic cfg_write;
      logic [5:0] cfg_reg_num;
      logic [3:0] cfg_be;
      logic [31:0] cfg_wdata;
      logic pci_req;
      logic [3:0] pci_cmd;
      logic [31:0] pci_addr;
      logic [3:0] pci_be;
      logic [31:0] pci_wdata;
      logic io_done;
      logic [31:0] io_rdata;
   } pcap_regs_type;

   pcap_regs_type r;
   pcap_regs_type nxt;
   logic [NUM_REQ-1:0] req_sync_n;
   logic [31:0] xl_addr;
   logic xl_own;
   logic xl_type1;
   logic hit_addr_port;
   logic hit_data_port;
   logic hit_pwr_arb;
   logic config_enable_bit;

   // ==========================================
   // request pin synchronisers
   pcap_sync #(
      .WIDTH(NUM_REQ),
      .INIT({NUM_REQ{1'b1}})
   ) u_req_sync (
      .mclk(mclk),
      .srst(srst),
      .async_in({southbridge_hold_request_n, pci_bus_req_n}),
      .sync_out(req_sync_n)
   );

   // ==========================================
   // address translation
   pcap_xlate u_xlate (
      .cfg_addr(r.config_address_port),
      .pci_addr(xl_addr),
      .is_own_target(xl_own),
      .is_type1(xl_type1)
   );

   assign config_enable_bit = r.config_address_port[PCAP_ENABLE_POS];
   // address port needs all four lanes
   assign hit_addr_port = (io_addr[15:2] == PCAP_CFG_ADDR_PORT[15:2])
                          && (io_be == PCAP_FULL_DWORD_BE);
   // disabled data port falls through to i/o
   assign hit_data_port = (io_addr[15:2] == PCAP_CFG_DATA_PORT[15:2]) && config_enable_bit;
   // hidden until misc control bit 6 set
   assign hit_pwr_arb = (io_addr[15:2] == PCAP_PWR_ARB_ADDR[15:2])
                        && (io_be == PCAP_PWR_ARB_BE) && r.misc_pm_enable;

   // ==========================================
   // next state
   always_comb begin
      nxt = r;
      nxt.io_done = 1'b0;
      nxt.cfg_req = 1'b0;
      nxt.pci_req = 1'b0;
      case (r.st)
         PCAP_IDLE: begin
            if (io_valid) begin
               if (hit_addr_port) begin
                  if (io_write) begin
                     nxt.config_address_port = io_wdata & PCAP_CFG_ADDR_WMASK;
                  end
                  nxt.io_rdata = r.config_address_port;
                  nxt.io_done = 1'b1;
                  // busy for one cycle, like the power arbiter answer
                  nxt.st = PCAP_DONE;
               end else if (hit_pwr_arb) begin
                  if (io_write) begin
                     // reserved bits 7:1 stay zero
                     nxt.power_arbiter_control = {7'h00, io_wdata[16 + PCAP_ARBITER_DISABLE_BIT_POS]};
                  end
                  nxt.io_rdata = {8'h00, r.power_arbiter_control, 16'h0000};
                  nxt.io_done = 1'b1;
                  nxt.st = PCAP_DONE;
               end else if (hit_data_port && xl_own) begin
                  // only host side reaches cfg port
                  // register field picks one of 64 dwords
                  nxt.cfg_req = 1'b1;
                  nxt.cfg_write = io_write;
                  nxt.cfg_reg_num = r.config_address_port[7:2];
                  nxt.cfg_be = io_be;
                  nxt.cfg_wdata = io_wdata;
                  nxt.st = PCAP_INT_WAIT;
                  // snoop the misc control byte to open the arbiter register
                  if (io_write && r.config_address_port[7:2] == PCAP_MISC_CTRL_DW
                      && io_be[PCAP_MISC_CTRL_LANE]) begin
                     nxt.misc_pm_enable = io_wdata[PCAP_MISC_PM_BIT];
                  end
               end else if (hit_data_port) begin
                  // enabled data access becomes config cycle
                  nxt.pci_req = 1'b1;
                  nxt.pci_cmd = io_write ? PCAP_CMD_CFG_WR : PCAP_CMD_CFG_RD;
                  nxt.pci_addr = xl_addr;
                  nxt.pci_be = io_be;
                  nxt.pci_wdata = io_wdata;
                  nxt.st = PCAP_PCI_WAIT;
               end else begin
                  // any access not claimed above, narrow address port included, forwarded as i/o
                  nxt.pci_req = 1'b1;
                  nxt.pci_cmd = io_write ? PCAP_CMD_IO_WR : PCAP_CMD_IO_RD;
                  nxt.pci_addr = {16'h0000, io_addr[15:2], 2'b00};
                  nxt.pci_be = io_be;
                  nxt.pci_wdata = io_wdata;
                  nxt.st = PCAP_PCI_WAIT;
               end
            end
         end
         PCAP_INT_WAIT: begin
            if (cfg_ack) begin
               nxt.io_rdata = cfg_rdata;
               nxt.io_done = 1'b1;
               nxt.st = PCAP_DONE;
            end
         end
         PCAP_PCI_WAIT: begin
            // a master abort still acks; engine returns all ones then
            if (pci_ack) begin
               nxt.io_rdata = pci_rdata;
               nxt.io_done = 1'b1;
               nxt.st = PCAP_DONE;
            end
         end
         PCAP_DONE: begin
            nxt.st = PCAP_IDLE;
         end
         default: begin
            nxt.st = PCAP_IDLE;
         end
      endcase
   end

   // ==========================================
   // state register
   always_ff @(posedge mclk) begin
      if (srst) begin
         r <= '0;
         r.st <= PCAP_IDLE;
         r.config_address_port <= PCAP_CFG_ADDR_RESET;
         r.power_arbiter_control <= PCAP_PWR_ARB_RESET;
      end else begin
         r <= nxt;
      end
   end

   // ==========================================
   // outputs
   assign io_ready = (r.st == PCAP_IDLE);
   assign io_done = r.io_done;
   assign io_rdata = r.io_rdata;
   assign cfg_req = r.cfg_req;
   assign cfg_write = r.cfg_write;
   assign cfg_reg_num = r.cfg_reg_num;
   assign cfg_be = r.cfg_be;
   assign cfg_wdata = r.cfg_wdata;
   assign pci_req = r.pci_req;
   assign pci_cmd = r.pci_cmd;
   assign pci_addr = r.pci_addr;
   assign pci_be = r.pci_be;
   assign pci_wdata = r.pci_wdata;
   assign arbiter_disable_bit = r.power_arbiter_control[PCAP_ARBITER_DISABLE_BIT_POS];
   assign arb_req_active = ~req_sync_n & {NUM_REQ{~arbiter_disable_bit}};
endmodule

// file: testbench/pcap_checker.sv
`timescale 1ns/1ps
module pcap_checker
   import pcap_pkg::*;
#(
   parameter int NUM_REQ = PCAP_NUM_REQ
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic io_valid,
   input wire logic io_ready,
   input wire logic io_write,
   input wire logic [15:0] io_addr,
   input wire logic [3:0] io_be,
   input wire logic io_done,
   input wire logic cfg_req,
   input wire logic cfg_ack,
   input wire logic pci_req,
   input wire logic [3:0] pci_cmd,
   input wire logic [31:0] pci_addr,
   input wire logic pci_ack,
   input wire logic [NUM_REQ-1:0] arb_req_active,
   input wire logic arbiter_disable_bit
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);
   logic take;
   logic at_addr;
   logic cfg_cyc;
   assign take = io_valid && io_ready;
   assign at_addr = io_addr[15:2] == PCAP_CFG_ADDR_PORT[15:2];
   assign cfg_cyc = pci_req && pci_cmd[3:1] == 3'b101;
   // ==========================================
   // answer then idle again
   sequence s_close;
      io_done && !io_ready ##1 io_ready;
   endsequence
   arb_mask_a: assert property (arbiter_disable_bit |-> arb_req_active == '0)
      else $error("request seen while arbiter disabled");
   addr_port_a: assert property (take && at_addr && io_be == PCAP_FULL_DWORD_BE
      |=> io_done && !pci_req && !cfg_req) else $error("address port not claimed");
   narrow_port_a: assert property (take && at_addr && io_be != PCAP_FULL_DWORD_BE
      |=> pci_req && pci_cmd == ($past(io_write) ? PCAP_CMD_IO_WR : PCAP_CMD_IO_RD))
      else $error("narrow address port access not forwarded");
   type0_sel_a: assert property (cfg_cyc && pci_addr[1:0] == 2'b00
      |-> $onehot0(pci_addr[31:11]) && !pci_addr[11]) else $error("bad select lines");
   type1_form_a: assert property (cfg_cyc && pci_addr[1:0] != 2'b00
      |-> pci_addr[1:0] == 2'b01 && pci_addr[31:24] == 8'h00) else $error("bad type 1");
   answer_a: assert property ((cfg_ack || pci_ack) |=> s_close)
      else $error("no answer after acknowledge");
   busy_a: assert property (take |=> !io_ready)
      else $error("second request accepted");
   req_cause_a: assert property ((cfg_req || pci_req) |-> $past(take))
      else $error("cycle without host request");
endmodule
bind pcap_top pcap_checker #(.NUM_REQ(NUM_REQ)) u_chk (.mclk, .srst, .io_valid, .io_ready,
   .io_write, .io_addr, .io_be, .io_done, .cfg_req, .cfg_ack, .pci_req, .pci_cmd, .pci_addr,
   .pci_ack, .arb_req_active, .arbiter_disable_bit);

// file: testbench/pcap_far_model.sv
`timescale 1ns/1ps
module pcap_far_model
   import pcap_pkg::*;
(
   input wire logic mclk,
   input wire logic slow,
   input wire logic cfg_req,
   input wire logic cfg_write,
   input wire logic [5:0] cfg_reg_num,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic cfg_ack = 1'b0,
   output logic [31:0] cfg_rdata = 32'h0,
   input wire logic pci_req,
   input wire logic [3:0] pci_cmd,
   input wire logic [31:0] pci_addr,
   output logic pci_ack = 1'b0,
   output logic [31:0] pci_rdata = 32'h0
);
   // 64 dwords
   // cleared so partly written dwords read back known bytes
   logic [31:0] mem [64] = '{default: 32'h0};
   logic [2:0] cw = 3'd0;
   logic [2:0] pw = 3'd0;
   always_ff @(posedge mclk) begin
      cfg_ack <= 1'b0;
      pci_ack <= 1'b0;
      // idle data is scrambled so a stale read cannot match
      cfg_rdata <= ~cfg_rdata;
      pci_rdata <= ~pci_rdata;
      if (cw != 3'd0) cw <= cw - 3'd1;
      if (pw != 3'd0) pw <= pw - 3'd1;
      if (cfg_req) cw <= slow ? 3'd5 : 3'd1;
      if (pci_req) pw <= slow ? 3'd5 : 3'd1;
      if (cw == 3'd1) begin
         cfg_ack <= 1'b1;
         cfg_rdata <= mem[cfg_reg_num];
         for (int i = 0; i < 4; i++) begin
            if (cfg_write && cfg_be[i]) mem[cfg_reg_num][8*i +: 8] <= cfg_wdata[8*i +: 8];
         end
      end
      if (pw == 3'd1) begin
         pci_ack <= 1'b1;
         // no select line ends in master abort
         pci_rdata <= (pci_cmd == PCAP_CMD_CFG_RD && pci_addr[1:0] == 2'b00 &&
            pci_addr[31:11] == 21'h0) ? 32'hffff_ffff : ~pci_addr;
      end
   end
endmodule

// file: testbench/pcap_bench.sv
`timescale 1ns/1ps
module pcap_bench;
   import pcap_pkg::*;
   logic mclk = 1'b0, srst = 1'b1, io_valid = 1'b0, io_write = 1'b0, slow = 1'b0;
   logic southbridge_hold_request_n = 1'b1;
   logic [15:0] io_addr = 16'h0;
   logic [3:0] io_be = 4'h0, pci_bus_req_n = 4'hf, cfg_be, pci_cmd, pci_be;
   logic [31:0] io_wdata = 32'h0, r, e, io_rdata, cfg_wdata, cfg_rdata, pci_addr, pci_wdata;
   logic [31:0] pci_rdata;
   logic io_ready, io_done, cfg_req, cfg_write, cfg_ack, pci_req, pci_ack, arbiter_disable_bit;
   logic [5:0] cfg_reg_num;
   logic [4:0] arb_req_active;
   int error_cnt = 0, num_checks = 0;
   always #5 mclk = ~mclk;
   pcap_top dut (.mclk, .srst, .io_valid, .io_ready, .io_write, .io_addr, .io_be, .io_wdata,
      .io_done, .io_rdata, .cfg_req, .cfg_write, .cfg_reg_num, .cfg_be, .cfg_wdata, .cfg_ack,
      .cfg_rdata, .pci_req, .pci_cmd, .pci_addr, .pci_be, .pci_wdata, .pci_ack, .pci_rdata,
      .pci_bus_req_n, .southbridge_hold_request_n, .arb_req_active, .arbiter_disable_bit);
   pcap_far_model far (.mclk, .slow, .cfg_req, .cfg_write, .cfg_reg_num, .cfg_be, .cfg_wdata,
      .cfg_ack, .cfg_rdata, .pci_req, .pci_cmd, .pci_addr, .pci_ack, .pci_rdata);
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(inout int n);
      @(negedge mclk);
      n++;
      if (n > 60) begin
         error_cnt++;
         print_verdict();
      end
   endtask
   // one host access; request raised once io_ready seen and held one cycle, answer sampled mid-cycle
   task automatic io(input logic w, input logic [15:0] a, input logic [3:0] be,
      input logic [31:0] d);
      int n;
      n = 0;
      tick(n);
      while (io_ready !== 1'b1) tick(n);
      @(posedge mclk);
      io_valid <= 1'b1;
      io_write <= w;
      io_addr <= a;
      io_be <= be;
      io_wdata <= d;
      @(posedge mclk);
      io_valid <= 1'b0;
      do tick(n); while (io_done !== 1'b1);
      r = io_rdata;
   endtask
   initial begin
      repeat (5) @(posedge mclk);
      srst <= 1'b0;
      io(1'b0, 16'h0cf8, 4'hf, 32'h0);
      chk(r, 32'h0);
      io(1'b1, 16'h0cf8, 4'hf, 32'hffff_ffff);
      io(1'b0, 16'h0cf8, 4'hf, 32'h0);
      chk(r, 32'h80ff_fffc);
      io(1'b0, 16'h0cf8, 4'h1, 32'h0);
      chk(r, ~32'h0000_0cf8);
      chk({28'h0, pci_be}, 32'h1);
      io(1'b1, 16'h0cf8, 4'hf, 32'h0);
      io(1'b0, 16'h0cfc, 4'hf, 32'h0);
      chk(r, ~32'h0000_0cfc);
      // power register stays hidden until the misc bit is set
      io(1'b1, 16'h0020, 4'h4, 32'h0001_0000);
      chk({28'h0, pci_cmd}, 32'h3);
      chk({31'h0, arbiter_disable_bit}, 32'h0);
      io(1'b1, 16'h0cf8, 4'hf, 32'h8000_0078);
      io(1'b1, 16'h0cfc, 4'h2, 32'h0000_4000);
      io(1'b1, 16'h0cfc, 4'h1, 32'hffff_ffaa);
      io(1'b0, 16'h0cfc, 4'hf, 32'h0);
      chk(r, 32'h0000_40aa);
      io(1'b1, 16'h0020, 4'h4, 32'h0001_0000);
      @(posedge mclk);
      pci_bus_req_n <= 4'h0;
      southbridge_hold_request_n <= 1'b0;
      io(1'b0, 16'h0020, 4'h4, 32'h0);
      chk({24'h0, r[23:16]}, 32'h1);
      chk({27'h0, arb_req_active}, 32'h0);
      io(1'b1, 16'h0020, 4'h4, 32'h0);
      @(negedge mclk);
      chk({27'h0, arb_req_active}, 32'h1f);
      for (int d = 0; d < 22; d++) begin
         io(1'b1, 16'h0cf8, 4'hf, {16'h8000, d[4:0], 11'h314});
         io(1'b0, 16'h0cfc, 4'hf, 32'h0);
         e = 32'h314 | ((d > 0 && d < 21) ? 32'h1 << (11 + d) : 32'h0);
         chk(pci_addr, e);
         chk(r, (d > 0 && d < 21) ? ~e : 32'hffff_ffff);
      end
      slow <= 1'b1;
      io(1'b1, 16'h0cf8, 4'hf, 32'h805a_3afc);
      io(1'b1, 16'h0cfc, 4'hf, 32'h1234_5678);
      chk({28'h0, pci_cmd}, 32'hb);
      chk(pci_addr, 32'h005a_3afd);
      chk(pci_wdata, 32'h1234_5678);
      chk({28'h0, pci_be}, 32'hf);
      io(1'b0, 16'h0cfc, 4'hf, 32'h0);
      chk(r, ~32'h005a_3afd);
      print_verdict();
   end
endmodule
